//--- alu_exec_cfg.svh
// Offsets, field positions, reset values and counts for the execute stage.
`ifndef ALU_EXEC_CFG_SVH
`define ALU_EXEC_CFG_SVH

// Memory-mapped special registers in the file space.
`define ADDR_PC_LOW     8'h02
`define ADDR_FLAGS      8'h03
`define ADDR_PTR        8'h04

// Operand field decode.
`define FSEL_INDIRECT   5'h00
`define FSEL_BANKED_MIN 5'h10
`define NULL_ADDR       8'h00
`define BANK_MSB        7
`define BANK_LSB        5
`define OPC_MSB         11
`define OPC_LSB         5
`define LIT_OPC_LSB     8

// Flag positions in flags_and_page.
`define FLAG_C          0
`define FLAG_DC         1
`define FLAG_Z          2
`define FLAG_PD         3
`define FLAG_TO         4
`define PAGE_MSB        7
`define PAGE_LSB        5

// Reset values.
`define FLAGS_RESET     8'h18
`define ACC_RESET       8'h00
`define PTR_RESET       8'h00
`define PC_RESET        8'h00

// Whole-word encodings and constants.
`define OPC_CLR_WDT     12'h004
`define ONES_MASK       8'hff

// Last count of the instruction-rate divider: divide by one or by four.
`define DIV_TURBO_LAST  2'h0
`define DIV_COMPAT_LAST 2'h3

`endif

//--- alu_exec_pkg.sv
// Types shared by the execute stage: opcodes and sequencer states.
package alu_exec_pkg;

   // Upper seven bits of the file-register instructions.
   typedef enum logic [6:0] {
      OP_AND_FW   = 7'h0b,
      OP_AND_WF   = 7'h0a,
      OP_NOT_F    = 7'h13,
      OP_OR_FW    = 7'h09,
      OP_OR_WF    = 7'h08,
      OP_XOR_FW   = 7'h0d,
      OP_XOR_WF   = 7'h0c,
      OP_ADD_FW   = 7'h0f,
      OP_ADD_WF   = 7'h0e,
      OP_SUB_FW   = 7'h05,
      OP_DEC_F    = 7'h07,
      OP_DEC_SKZ  = 7'h17,
      OP_INC_F    = 7'h15,
      OP_INC_SKZ  = 7'h1f,
      OP_ROT_L    = 7'h1b,
      OP_ROT_R    = 7'h19,
      OP_SWAP_F   = 7'h1d
   } file_op_t;

   // Upper four bits of the literal instructions.
   typedef enum logic [3:0] {
      LIT_AND = 4'he,
      LIT_OR  = 4'hd,
      LIT_XOR = 4'hf
   } lit_op_t;

   typedef enum logic [0:0] {
      ST_RUN  = 1'b0,
      ST_SKIP = 1'b1
   } exec_state_t;

endpackage : alu_exec_pkg

//--- alu_step_div.sv
// Instruction-rate divider: one step per clock or one per four clocks.
`timescale 1ns/1ps
`include "alu_exec_cfg.svh"

module alu_step_div #(
   parameter int unsigned CNT_W = 2
) (
   input  wire logic clk_sys,        // System clock.
   input  wire logic rst,            // Asynchronous reset, active high.
   input  wire logic ce,             // Clock enable, freezes the divider when low.
   input  wire logic turbo_clocking, // 1 selects divide by one.
   output logic      tick_q          // One-cycle instruction step.
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] limit;
   logic             tick_d;

   always_comb begin
      limit  = turbo_clocking ? CNT_W'(`DIV_TURBO_LAST) : CNT_W'(`DIV_COMPAT_LAST);
      // Greater-or-equal lets a mode change mid-count settle without a long wrap.
      tick_d = (cnt_q >= limit);
      cnt_d  = tick_d ? '0 : cnt_q + 1'b1;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else if (ce) begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

endmodule : alu_step_div

//--- alu_instruction_execute.sv
// Execute stage for the logical, arithmetic, shift and rotate instructions.
`timescale 1ns/1ps
`include "alu_exec_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - AND file with accumulator into file; zero flag updated.
// - AND accumulator with file into accumulator; zero flag updated.
// - Literal AND, OR, XOR into accumulator; zero flag updated.
// - Complement file register in place; zero flag updated.
// - OR file with accumulator into file; zero flag updated.
// - OR accumulator with file into accumulator; zero flag updated.
// - XOR file with accumulator into file; zero flag updated.
// - XOR accumulator with file into accumulator; zero flag updated.
// - Add accumulator into file, carry joins when select clear; C, DC, Z.
// - Add file into accumulator, carry joins when select clear; C, DC, Z.
// - Watchdog clear instruction clears counter, prescaler when assigned to watchdog, sets timeout and sleep flags.
// - Decrement file register in one cycle; zero flag updated.
// - Decrement file, skip next on zero result; no flags touched.
// - Increment file register in one cycle; zero flag updated.
// - Increment file, skip next on zero result; no flags touched.
// - Rotate file left or right through carry; only carry changes.
// - Swap file register nibbles in place; no flags touched.
// - Flags layout: C0, DC1, Z2, sleep3, timeout4, page 7:5.
// - Step rate is the clock, or a quarter of it, by fuse.
// - Operand field selects a register in the 00h to FFh space.
module alu_instruction_execute
   import alu_exec_pkg::*;
(
   input  wire logic        clk_sys,                  // System clock, 50 MHz.
   input  wire logic        rst,                      // Asynchronous reset, active high.
   input  wire logic        ce,                       // Clock enable, freezes all state.
   input  wire logic        turbo_clocking,           // Fuse: 1 = one step per clock.
   input  wire logic        carry_chain_select,       // Fuse: 0 = carry joins add/sub.
   input  wire logic        prescaler_on_wdt,         // Prescaler assigned to watchdog.
   input  wire logic [11:0] instr,                    // Instruction word.
   input  wire logic        instr_valid,              // Instruction word is present.
   output logic             instr_strobe_q,           // Step slot of the divider.
   output logic             instr_taken_q,            // Instruction consumed last cycle.
   output logic [7:0]       acc_q,                    // Accumulator.
   output logic [7:0]       flags_and_page_q,         // Flags and page bits.
   output logic [7:0]       indirect_pointer_q,       // Indirect pointer.
   output logic [7:0]       program_counter_low_q,    // Program counter low byte.
   output logic             skip_pending_q,           // Next instruction is skipped.
   output logic             watchdog_counter_clear_q, // Clear pulse to watchdog.
   output logic             prescaler_clear_q         // Clear pulse to prescaler.
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   exec_state_t state_q;
   exec_state_t state_d;
   logic [7:0]  acc_d;
   logic [7:0]  flags_d;
   logic [7:0]  ptr_d;
   logic [7:0]  pc_d;
   logic        taken_d;
   logic        skip_d;
   logic        wdc_d;
   logic        psc_d;
   logic        step_tick;
   logic        take;
   logic [6:0]  opc;
   logic [7:0]  lit;
   logic [4:0]  fsel;
   logic [7:0]  f_addr;
   logic        f_null;
   logic [7:0]  f_val;
   logic [7:0]  add_b;
   logic        add_cin;
   logic [8:0]  sum9;
   logic [4:0]  sum5;
   logic [7:0]  res;
   logic        wr_f;
   logic        wr_w;
   logic        upd_z;
   logic        upd_arith;
   logic        upd_c;
   logic        new_c;
   logic        mem_we;
   logic [7:0]  file_mem [0:255];

   ////////////////////////////////////////////////////////////////////////////
   // Instruction rate.

   alu_step_div #(
      .CNT_W (2)
   ) u_step_div (
      .clk_sys        (clk_sys),
      .rst            (rst),
      .ce             (ce),
      .turbo_clocking (turbo_clocking),
      .tick_q         (step_tick)
   );

   assign instr_strobe_q = step_tick;
   assign take           = step_tick & instr_valid;

   ////////////////////////////////////////////////////////////////////////////
   // Operand address and read.

   always_comb begin
      opc    = instr[`OPC_MSB:`OPC_LSB];
      lit    = instr[7:0];
      fsel   = instr[4:0];
      f_null = 1'b0;
      if (fsel == `FSEL_INDIRECT) begin
         f_addr = indirect_pointer_q;
         // Pointing the pointer at itself-as-indirect reads zero and writes nothing.
         f_null = (indirect_pointer_q == `NULL_ADDR);
      end else if (fsel < `FSEL_BANKED_MIN) begin
         f_addr = {3'h0, fsel};
      end else begin
         f_addr = {indirect_pointer_q[`BANK_MSB:`BANK_LSB], fsel};
      end
      if (f_null) begin
         f_val = 8'h00;
      end else begin
         case (f_addr)
            `ADDR_PC_LOW: f_val = program_counter_low_q;
            `ADDR_FLAGS:  f_val = flags_and_page_q;
            `ADDR_PTR:    f_val = indirect_pointer_q;
            default:      f_val = file_mem[f_addr];
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Adder shared by add and subtract.

   always_comb begin
      add_b   = (opc == OP_SUB_FW) ? ~acc_q : acc_q;
      // Subtract is add of the complement, so its carry-in of one is the borrow-free case.
      if (carry_chain_select) begin
         add_cin = (opc == OP_SUB_FW);
      end else begin
         add_cin = flags_and_page_q[`FLAG_C];
      end
      sum9 = {1'b0, f_val} + {1'b0, add_b} + {8'h00, add_cin};
      sum5 = {1'b0, f_val[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Execute.

   always_comb begin
      acc_d     = acc_q;
      flags_d   = flags_and_page_q;
      ptr_d     = indirect_pointer_q;
      pc_d      = program_counter_low_q;
      state_d   = state_q;
      taken_d   = 1'b0;
      wdc_d     = 1'b0;
      psc_d     = 1'b0;
      mem_we    = 1'b0;
      res       = 8'h00;
      wr_f      = 1'b0;
      wr_w      = 1'b0;
      upd_z     = 1'b0;
      upd_arith = 1'b0;
      upd_c     = 1'b0;
      new_c     = 1'b0;
      if (take) begin
         taken_d = 1'b1;
         pc_d    = program_counter_low_q + 8'h01;
         case (state_q)
            ST_SKIP: begin
               state_d = ST_RUN;
            end
            ST_RUN: begin
               if (instr == `OPC_CLR_WDT) begin
                  wdc_d             = 1'b1;
                  psc_d             = prescaler_on_wdt;
                  flags_d[`FLAG_TO] = 1'b1;
                  flags_d[`FLAG_PD] = 1'b1;
               end else if (instr[`OPC_MSB:`LIT_OPC_LSB] == LIT_AND) begin
                  res   = acc_q & lit;
                  wr_w  = 1'b1;
                  upd_z = 1'b1;
               end else if (instr[`OPC_MSB:`LIT_OPC_LSB] == LIT_OR) begin
                  res   = acc_q | lit;
                  wr_w  = 1'b1;
                  upd_z = 1'b1;
               end else if (instr[`OPC_MSB:`LIT_OPC_LSB] == LIT_XOR) begin
                  res   = acc_q ^ lit;
                  wr_w  = 1'b1;
                  upd_z = 1'b1;
               end else begin
                  case (opc)
                     OP_AND_FW: begin
                        res = f_val & acc_q;
                        {wr_f, upd_z} = 2'h3;
                     end
                     OP_AND_WF: begin
                        res = acc_q & f_val;
                        {wr_w, upd_z} = 2'h3;
                     end
                     OP_NOT_F: begin
                        res = f_val ^ `ONES_MASK;
                        {wr_f, upd_z} = 2'h3;
                     end
                     OP_OR_FW: begin
                        res = f_val | acc_q;
                        {wr_f, upd_z} = 2'h3;
                     end
                     OP_OR_WF: begin
                        res = acc_q | f_val;
                        {wr_w, upd_z} = 2'h3;
                     end
                     OP_XOR_FW: begin
                        res = f_val ^ acc_q;
                        {wr_f, upd_z} = 2'h3;
                     end
                     OP_XOR_WF: begin
                        res = acc_q ^ f_val;
                        {wr_w, upd_z} = 2'h3;
                     end
                     OP_ADD_FW, OP_SUB_FW: begin
                        res = sum9[7:0];
                        {wr_f, upd_arith} = 2'h3;
                     end
                     OP_ADD_WF: begin
                        res = sum9[7:0];
                        {wr_w, upd_arith} = 2'h3;
                     end
                     OP_DEC_F: begin
                        res = f_val - 8'h01;
                        {wr_f, upd_z} = 2'h3;
                     end
                     OP_INC_F: begin
                        res = f_val + 8'h01;
                        {wr_f, upd_z} = 2'h3;
                     end
                     OP_DEC_SKZ, OP_INC_SKZ: begin
                        res  = (opc == OP_DEC_SKZ) ? f_val - 8'h01 : f_val + 8'h01;
                        wr_f = 1'b1;
                        if (res == 8'h00) begin
                           state_d = ST_SKIP;
                        end
                     end
                     OP_ROT_L: begin
                        res   = {f_val[6:0], flags_and_page_q[`FLAG_C]};
                        new_c = f_val[7];
                        {wr_f, upd_c} = 2'h3;
                     end
                     OP_ROT_R: begin
                        res   = {flags_and_page_q[`FLAG_C], f_val[7:1]};
                        new_c = f_val[0];
                        {wr_f, upd_c} = 2'h3;
                     end
                     OP_SWAP_F: begin
                        res  = {f_val[3:0], f_val[7:4]};
                        wr_f = 1'b1;
                     end
                     default: begin
                        res = 8'h00;
                     end
                  endcase
               end
               if (wr_w) begin
                  acc_d = res;
               end
               // A result aimed at a special register lands there; the flag update
               // below still wins on the bits it owns.
               if (wr_f && !f_null) begin
                  case (f_addr)
                     `ADDR_PC_LOW: pc_d  = res;
                     `ADDR_PTR:    ptr_d = res;
                     `ADDR_FLAGS: begin
                        // Timeout and sleep flags are not writable by data.
                        flags_d = {res[`PAGE_MSB:`PAGE_LSB],
                                   flags_and_page_q[`FLAG_TO:`FLAG_PD],
                                   res[`FLAG_Z:`FLAG_C]};
                     end
                     default:      mem_we = 1'b1;
                  endcase
               end
               if (upd_z || upd_arith) begin
                  flags_d[`FLAG_Z] = (res == 8'h00);
               end
               if (upd_arith) begin
                  flags_d[`FLAG_C]  = sum9[8];
                  flags_d[`FLAG_DC] = sum5[4];
               end
               if (upd_c) begin
                  flags_d[`FLAG_C] = new_c;
               end
            end
            default: begin
               state_d = ST_RUN;
            end
         endcase
      end
      skip_d = (state_d == ST_SKIP);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers.

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q                  <= ST_RUN;
         acc_q                    <= `ACC_RESET;
         flags_and_page_q         <= `FLAGS_RESET;
         indirect_pointer_q       <= `PTR_RESET;
         program_counter_low_q    <= `PC_RESET;
         instr_taken_q            <= 1'b0;
         skip_pending_q           <= 1'b0;
         watchdog_counter_clear_q <= 1'b0;
         prescaler_clear_q        <= 1'b0;
      end else if (ce) begin
         state_q                  <= state_d;
         acc_q                    <= acc_d;
         flags_and_page_q         <= flags_d;
         indirect_pointer_q       <= ptr_d;
         program_counter_low_q    <= pc_d;
         instr_taken_q            <= taken_d;
         skip_pending_q           <= skip_d;
         watchdog_counter_clear_q <= wdc_d;
         prescaler_clear_q        <= psc_d;
      end
   end

   // General file registers carry no reset, as on a RAM.
   always_ff @(posedge clk_sys) begin
      if (ce && mem_we) begin
         file_mem[f_addr] <= res;
      end
   end

endmodule : alu_instruction_execute

//--- alu_exec_asserts.sv
// Concurrent checks on the ports of the instruction execute stage.
`timescale 1ns/1ps

module alu_exec_asserts
   import alu_exec_pkg::*;
(
   input wire logic        clk_sys,                  // System clock.
   input wire logic        rst,                      // Asynchronous reset, active high.
   input wire logic        ce,                       // Clock enable.
   input wire logic        turbo_clocking,           // Step-rate fuse.
   input wire logic        carry_chain_select,       // Carry fuse.
   input wire logic        prescaler_on_wdt,         // Prescaler assignment.
   input wire logic [11:0] instr,                    // Instruction word.
   input wire logic        instr_valid,              // Instruction present.
   input wire logic        instr_strobe_q,           // Step slot.
   input wire logic        instr_taken_q,            // Consumed pulse.
   input wire logic [7:0]  acc_q,                    // Accumulator.
   input wire logic [7:0]  flags_and_page_q,         // Flags and page bits.
   input wire logic [7:0]  indirect_pointer_q,       // Indirect pointer.
   input wire logic [7:0]  program_counter_low_q,    // Program counter low byte.
   input wire logic        skip_pending_q,           // Skip level.
   input wire logic        watchdog_counter_clear_q, // Watchdog clear pulse.
   input wire logic        prescaler_clear_q         // Prescaler clear pulse.
);

   ////////////////////////////////////////////////////////////////////////////////
   // A file operand of 00h or 03h may land on the flags, so flag checks avoid them.
   logic       step;
   logic       take;
   logic       safe_f;
   logic [6:0] opc;
   assign step   = ce && instr_strobe_q && instr_valid;
   assign take   = step && !skip_pending_q;
   assign opc    = instr[11:5];
   assign safe_f = (instr[4:0] != 5'h00) && (instr[4:0] != 5'h03);

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////////
   a_take_answer: assert property (step |=> instr_taken_q)
      else $error("instruction not acknowledged");
   a_taken_cause: assert property (instr_taken_q |-> $past(step))
      else $error("acknowledge without a step");
   a_strobe_turbo: assert property (turbo_clocking && instr_strobe_q |=> instr_strobe_q)
      else $error("turbo step slot dropped");
   a_strobe_compat_gap: assert property (!turbo_clocking && instr_strobe_q
      |=> !instr_strobe_q [*3] ##1 instr_strobe_q)
      else $error("compatible step not one in four");
   a_lit_and: assert property (take && instr[11:8] == 4'he
      |=> acc_q == ($past(acc_q) & $past(instr[7:0])) && flags_and_page_q[2] == (acc_q == 8'h00))
      else $error("literal and wrong");
   a_lit_or: assert property (take && instr[11:8] == 4'hd
      |=> acc_q == ($past(acc_q) | $past(instr[7:0])) && flags_and_page_q[2] == (acc_q == 8'h00))
      else $error("literal or wrong");
   a_lit_xor_zero: assert property (take && instr[11:8] == 4'hf
      |=> acc_q == ($past(acc_q) ^ $past(instr[7:0])) && flags_and_page_q[2] == (acc_q == 8'h00))
      else $error("literal xor wrong");
   a_wdt_clear: assert property (take && instr == 12'h004
      |=> watchdog_counter_clear_q && flags_and_page_q[4:3] == 2'b11)
      else $error("watchdog clear not done");
   a_prescaler_follow: assert property (prescaler_clear_q ==
      (watchdog_counter_clear_q && $past(prescaler_on_wdt)))
      else $error("prescaler clear mismatch");
   a_skip_no_flags: assert property (take && safe_f
      && (opc == OP_DEC_SKZ || opc == OP_INC_SKZ) |=> $stable(flags_and_page_q))
      else $error("skip instruction touched flags");
   a_skip_slot_nop: assert property (step && skip_pending_q
      |=> $stable(acc_q) && $stable(flags_and_page_q) && !skip_pending_q)
      else $error("skipped slot changed state");
   a_swap_no_flags: assert property (take && safe_f && opc == OP_SWAP_F
      |=> $stable(flags_and_page_q))
      else $error("swap touched flags");
   a_rotate_carry_only: assert property (take && safe_f
      && (opc == OP_ROT_L || opc == OP_ROT_R)
      |=> flags_and_page_q[7:1] == $past(flags_and_page_q[7:1]))
      else $error("rotate touched flags other than carry");

endmodule : alu_exec_asserts

//--- tb.sv
// Self-checking bench for the instruction execute stage.
`timescale 1ns/1ps
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
   import alu_exec_pkg::*;

   typedef struct packed {
      logic sel; file_op_t op; logic [7:0] f; logic [7:0] a; logic [7:0] r; logic [2:0] fl;
   } arith_t;

   logic        clk_sys, rst, ce, turbo_clocking, carry_chain_select, prescaler_on_wdt;
   logic        instr_valid, instr_strobe_q, instr_taken_q, skip_pending_q;
   logic        watchdog_counter_clear_q, prescaler_clear_q;
   logic [11:0] instr;
   logic [7:0]  acc_q, flags_and_page_q, indirect_pointer_q, program_counter_low_q, v, fl, p;
   logic [3:0]  lk;
   int          n_fail, n_tests, c;
   file_op_t    ops[6] = '{OP_AND_FW, OP_AND_WF, OP_OR_FW, OP_OR_WF, OP_XOR_FW, OP_XOR_WF};
   logic [3:0]  lits[3] = '{4'he, 4'hd, 4'hf};
   arith_t      ar[7] = '{'{1'b1, OP_ADD_WF, 8'hff, 8'h01, 8'h00, 3'b111},
                          '{1'b1, OP_ADD_FW, 8'h0f, 8'h01, 8'h10, 3'b010},
                          '{1'b1, OP_SUB_FW, 8'h05, 8'h06, 8'hff, 3'b000},
                          '{1'b0, OP_SUB_FW, 8'h05, 8'h02, 8'h02, 3'b011},
                          '{1'b0, OP_ADD_WF, 8'h01, 8'h01, 8'h03, 3'b000},
                          '{1'b0, OP_ADD_FW, 8'h80, 8'h80, 8'h00, 3'b101},
                          '{1'b0, OP_SUB_FW, 8'h00, 8'hff, 8'h01, 3'b000}};

   alu_instruction_execute alu_instruction_execute_inst (
      .clk_sys(clk_sys), .rst(rst), .ce(ce), .turbo_clocking(turbo_clocking),
      .carry_chain_select(carry_chain_select), .prescaler_on_wdt(prescaler_on_wdt),
      .instr(instr), .instr_valid(instr_valid), .instr_strobe_q(instr_strobe_q),
      .instr_taken_q(instr_taken_q), .acc_q(acc_q), .flags_and_page_q(flags_and_page_q),
      .indirect_pointer_q(indirect_pointer_q), .program_counter_low_q(program_counter_low_q),
      .skip_pending_q(skip_pending_q), .watchdog_counter_clear_q(watchdog_counter_clear_q),
      .prescaler_clear_q(prescaler_clear_q));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("Compares %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   // Valid stays up between words so it is never lowered and raised in one step.
   task automatic exec(input logic [11:0] w);
      int i;
      instr = w;
      instr_valid = 1'b1;
      @(negedge clk_sys);
      for (i = 0; i < 20 && instr_taken_q !== 1'b1; i++) @(negedge clk_sys);
      if (i == 20) begin
         n_fail++;
         stop_test();
      end
   endtask : exec

   task automatic quiet(input string name);
      instr_valid = 1'b0;
      @(negedge clk_sys);
      $display("Test %s done", name);
   endtask : quiet

   task automatic set_acc(input logic [7:0] x);
      exec(12'he00);
      exec({4'hd, x});
   endtask : set_acc

   // No move instruction here: a file register is built from and-zero then or.
   task automatic write_f(input logic [4:0] f, input logic [7:0] x);
      set_acc(8'h00);
      exec({OP_AND_FW, f});
      set_acc(x);
      exec({OP_OR_FW, f});
   endtask : write_f

   task automatic read_f(input logic [4:0] f, output logic [7:0] x);
      set_acc(8'hff);
      exec({OP_AND_WF, f});
      x = acc_q;
   endtask : read_f

   task automatic count_strobes(output int n);
      n = 0;
      repeat (16) begin
         @(negedge clk_sys);
         n += instr_strobe_q;
      end
   endtask : count_strobes

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, ce, turbo_clocking, carry_chain_select} = 4'hf;
      {prescaler_on_wdt, instr_valid, instr} = '0;
      n_fail = 0;
      n_tests = 0;
      repeat (5) @(negedge clk_sys);
      `CHECK({acc_q, flags_and_page_q, indirect_pointer_q, program_counter_low_q}, 32'h0018_0000)
      rst = 1'b0;
      @(negedge clk_sys);
      foreach (ops[k]) begin
         write_f(5'h05, 8'ha5);
         set_acc(8'h3c);
         exec({ops[k], 5'h05});
         `CHECK(flags_and_page_q[2], 1'b0)
         if (ops[k][0]) read_f(5'h05, v);
         else v = acc_q;
         lk = (ops[k] inside {OP_AND_FW, OP_AND_WF}) ? 4'he : (ops[k] inside {OP_OR_FW, OP_OR_WF}) ? 4'hd : 4'hf;
         `CHECK(v, (lk == 4'he) ? 8'h24 : (lk == 4'hd) ? 8'hbd : 8'h99)
      end
      foreach (lits[k]) begin
         set_acc(8'h3c);
         exec({lits[k], 8'hc3});
         `CHECK({acc_q, flags_and_page_q[2]}, (lits[k] == 4'he) ? 9'h001 : 9'h1fe)
      end
      write_f(5'h05, 8'hff);
      exec({OP_NOT_F, 5'h05});
      `CHECK(flags_and_page_q[2], 1'b1)
      read_f(5'h05, v);
      `CHECK(v, 8'h00)
      quiet("logic");
      foreach (ar[k]) begin
         write_f(5'h05, ar[k].f);
         set_acc(ar[k].a);
         carry_chain_select = ar[k].sel;
         exec({ar[k].op, 5'h05});
         `CHECK(flags_and_page_q[2:0], ar[k].fl)
         if (ar[k].op[0]) read_f(5'h05, v);
         else v = acc_q;
         `CHECK(v, ar[k].r)
      end
      quiet("arith");
      write_f(5'h06, 8'h01);
      fl = flags_and_page_q;
      exec({OP_ROT_R, 5'h06});
      `CHECK(flags_and_page_q, {fl[7:1], 1'b1})
      read_f(5'h06, v);
      `CHECK(v, 8'h00)
      write_f(5'h06, 8'h40);
      fl = flags_and_page_q;
      exec({OP_ROT_L, 5'h06});
      `CHECK(flags_and_page_q, {fl[7:1], 1'b0})
      read_f(5'h06, v);
      `CHECK(v, 8'h81)
      write_f(5'h06, 8'ha5);
      fl = flags_and_page_q;
      exec({OP_SWAP_F, 5'h06});
      `CHECK(flags_and_page_q, fl)
      read_f(5'h06, v);
      `CHECK(v, 8'h5a)
      write_f(5'h07, 8'hff);
      exec({OP_INC_F, 5'h07});
      `CHECK(flags_and_page_q[2], 1'b1)
      exec({OP_DEC_F, 5'h07});
      `CHECK({flags_and_page_q[2], skip_pending_q}, 2'b00)
      read_f(5'h07, v);
      `CHECK(v, 8'hff)
      exec({OP_INC_SKZ, 5'h07});
      `CHECK(skip_pending_q, 1'b1)
      p = program_counter_low_q;
      exec(12'hd11);
      `CHECK({acc_q, skip_pending_q, program_counter_low_q}, {8'hff, 1'b0, p + 8'h01})
      write_f(5'h07, 8'h02);
      fl = flags_and_page_q;
      exec({OP_DEC_SKZ, 5'h07});
      `CHECK(skip_pending_q, 1'b0)
      exec({OP_DEC_SKZ, 5'h07});
      `CHECK({skip_pending_q, flags_and_page_q}, {1'b1, fl})
      exec(12'he00);
      `CHECK(acc_q, 8'h02)
      quiet("rotate inc dec skip");
      prescaler_on_wdt = 1'b1;
      exec(12'h004);
      `CHECK({watchdog_counter_clear_q, prescaler_clear_q, flags_and_page_q[4:3]}, 4'hf)
      prescaler_on_wdt = 1'b0;
      exec(12'h004);
      `CHECK({watchdog_counter_clear_q, prescaler_clear_q}, 2'b10)
      quiet("watchdog");
      `CHECK(watchdog_counter_clear_q, 1'b0)
      write_f(5'h04, 8'h35);
      write_f(5'h00, 8'h77);
      read_f(5'h15, v);
      `CHECK({indirect_pointer_q, v}, 16'h3577)
      write_f(5'h04, 8'h00);
      write_f(5'h00, 8'h55);
      read_f(5'h00, v);
      `CHECK(v, 8'h00)
      quiet("addressing");
      {ce, instr_valid} = 2'b01;
      count_strobes(c);
      `CHECK(c[4:0], 5'd16)
      `CHECK(instr_taken_q, 1'b0)
      {ce, instr_valid} = 2'b10;
      rst = 1'b1;
      turbo_clocking = 1'b0;
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      count_strobes(c);
      `CHECK(c[4:0], 5'd4)
      set_acc(8'h42);
      `CHECK(acc_q, 8'h42)
      quiet("step rate");
      stop_test();
   end

endmodule : tb

bind alu_instruction_execute alu_exec_asserts alu_exec_asserts_inst (
   .clk_sys(clk_sys), .rst(rst), .ce(ce), .turbo_clocking(turbo_clocking),
   .carry_chain_select(carry_chain_select), .prescaler_on_wdt(prescaler_on_wdt),
   .instr(instr), .instr_valid(instr_valid), .instr_strobe_q(instr_strobe_q),
   .instr_taken_q(instr_taken_q), .acc_q(acc_q), .flags_and_page_q(flags_and_page_q),
   .indirect_pointer_q(indirect_pointer_q), .program_counter_low_q(program_counter_low_q),
   .skip_pending_q(skip_pending_q), .watchdog_counter_clear_q(watchdog_counter_clear_q),
   .prescaler_clear_q(prescaler_clear_q));
